// *** design/gpext_pkg.sv ***
// package: register map, field positions and types for the gpio port block
package gpext_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PORT_DATA_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_DIR_OFS = 8'h01;
  localparam logic [ADDR_W-1:0] PORT_OPT_OFS = 8'h02;
  localparam logic [ADDR_W-1:0] MISC_OFS = 8'h20;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int SMS_POS = 0;
  localparam int PSM_LO = 1;
  localparam int PEI01_LO = 3;
  localparam int MCO_POS = 5;
  localparam int PEI23_LO = 6;
  localparam int NUM_GROUPS = 4;
  localparam logic [5:0] DIV_NORMAL = 6'h02;
  localparam logic [5:0] DIV_SLOW0 = 6'h04;
  localparam logic [5:0] DIV_SLOW1 = 6'h10;
  localparam logic [5:0] DIV_SLOW2 = 6'h08;
  localparam logic [5:0] DIV_SLOW3 = 6'h20;

  typedef enum logic [1:0] {
    POL_FALL_LOW = 2'h0,
    POL_RISE = 2'h1,
    POL_FALL = 2'h2,
    POL_BOTH = 2'h3
  } gpext_pol_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpext_pad_t;
endpackage

// *** design/gpext_irq_det.sv ***
// one external interrupt group: and-combine, synchronise, detect, latch
module gpext_irq_det
  import gpext_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] member,
  input wire gpext_pol_t pol,
  input wire logic polChange,
  input wire logic ack,
  output logic request
);
  logic combined;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic edgeHit;
  logic pend_r;

  // non-member pins read as 1 so they never mask the group
  assign combined = &(pinIn | ~member); // [R6]

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      sync1_r <= combined; // [R22]
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_comb begin
    case (pol)
      POL_FALL_LOW: edgeHit = prev_r & ~sync2_r;
      POL_FALL: edgeHit = prev_r & ~sync2_r;
      POL_RISE: edgeHit = ~prev_r & sync2_r;
      POL_BOTH: edgeHit = prev_r ^ sync2_r;
      default: edgeHit = 1'b0;
    endcase
  end

  // set wins over ack; a polarity change clears a stale request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
    end else if (edgeHit) begin
      pend_r <= 1'b1; // [R22]
    end else if (polChange) begin
      pend_r <= 1'b0; // [R16]
    end else if (ack) begin
      pend_r <= 1'b0;
    end
  end

  // low level mode requests for as long as the level stays low
  assign request = pend_r | ((pol == POL_FALL_LOW) & ~sync2_r); // [R5]
endmodule

// *** design/gpext_port.sv ***
// gpio port with group interrupts, clock out and core clock prescaler
// Notes on behaviour
// [R1] direction clear: data read returns pin
// [R2] direction set: latch drives, reads latch
// [R3] bit x controls pin x only
// [R4] eight pins per port
// [R5] interrupt pin raises group request on event
// [R6] group pins anded before detection
// [R7] output pins never make interrupts
// [R8] peripheral drive overrides port programming; here the peripheral drives only while the pin's direction bit is clear
// [R9] peripheral input pin still readable
// [R10] software keeps shared peripheral pin input
// [R11] no peripheral on interrupt pin
// [R12] analog pin must be floating input
// [R13] write latch before switching to output
// [R14] bits 7:6 pick groups 2,3 event
// [R15] bits 4:3 pick groups 0,1 event
// [R16] polarity change clears group requests
// [R17] bit 5 drives core clock on f0
// [R18] slow divider 4,16,8,32 by bits 2:1
// [R19] bit 0 clear divides by two
// [R20] option: pull-up/interrupt or push-pull
// [R21] data write always updates latch
// [R22] synchronised sampled edge detection, latched
module gpext_port
  import gpext_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] GROUP0_PINS = 8'h0f,
  parameter logic [WIDTH-1:0] GROUP1_PINS = 8'h00,
  parameter logic [WIDTH-1:0] GROUP2_PINS = 8'h00,
  parameter logic [WIDTH-1:0] GROUP3_PINS = 8'hf0,
  parameter int CLKOUT_PIN = 0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic [WIDTH-1:0] pullUpEn,
  input wire logic [WIDTH-1:0] altEn,
  input wire logic [WIDTH-1:0] altOut,
  input wire logic [WIDTH-1:0] altPushPull,
  output logic [WIDTH-1:0] altIn,
  input wire logic [NUM_GROUPS-1:0] irqAck,
  output logic [NUM_GROUPS-1:0] extIrq,
  input wire logic osc_clk_en,
  output logic coreClockEn,
  output logic coreClockLevel,
  output logic slowModeSelect,
  output logic [1:0] slowClockDivider
);
  // elaboration checks: the pad logic serves one to eight pins
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("port width must be 1 to 8"); // [R4]
  end
  if (CLKOUT_PIN < 0 || CLKOUT_PIN >= WIDTH) begin : g_bad_clk_pin
    $error("clock out pin out of range");
  end
  // the pair decode assumes exactly four vectors
  if (NUM_GROUPS != 4) begin : g_bad_groups
    $error("four interrupt groups expected");
  end

  logic [WIDTH-1:0] portDataLatch_r;
  logic [WIDTH-1:0] dir_r;
  logic [WIDTH-1:0] opt_r;
  logic [7:0] misc_r;
  logic [7:0] misc_nxt;
  logic [7:0] regRdata_r;
  logic [7:0] readMux;
  logic [WIDTH-1:0] irqCapable;
  logic [NUM_GROUPS-1:0] polChange;
  logic [5:0] divCnt_r;
  logic [5:0] divLimit;
  logic coreClkEn_r;
  logic coreClk_r;
  logic [WIDTH-1:0] pinOut_r;
  logic [WIDTH-1:0] pinOe_r;
  logic [WIDTH-1:0] pullUp_r;
  logic [WIDTH-1:0] pinOut_nxt;
  logic [WIDTH-1:0] pinOe_nxt;
  logic [WIDTH-1:0] pullUp_nxt;
  logic [WIDTH-1:0] pinView;
  logic divWrap;
  logic divHalf;
  logic clkOutSel;
  logic slowSel;
  logic [1:0] slowDiv;

  function automatic logic [WIDTH-1:0] widen(input logic [7:0] v);
    widen = v[WIDTH-1:0];
  endfunction

  // pin bits above WIDTH read as zero
  function automatic logic [7:0] pad8(input logic [WIDTH-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[WIDTH-1:0] = v;
    pad8 = r;
  endfunction

  // write decode shared by every register process
  function automatic logic wrHit(input logic wr, input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs);
    wrHit = wr && (addr == ofs);
  endfunction

  // true when a polarity pair is rewritten with a new value
  function automatic logic pairChanged(input logic [1:0] a, input logic [1:0] b);
    pairChanged = a != b;
  endfunction

  // groups 0,1 follow bits 4:3, groups 2,3 bits 7:6
  function automatic gpext_pol_t groupPol(input int g, input logic [7:0] m);
    if (g < 2) begin
      groupPol = gpext_pol_t'(m[PEI01_LO +: 2]); // [R15]
    end else begin
      groupPol = gpext_pol_t'(m[PEI23_LO +: 2]); // [R14]
    end
  endfunction

  // membership of each pin in the four vectors, fixed at build time
  function automatic logic [WIDTH-1:0] groupMask(input int g);
    case (g)
      0: groupMask = GROUP0_PINS;
      1: groupMask = GROUP1_PINS;
      2: groupMask = GROUP2_PINS;
      3: groupMask = GROUP3_PINS;
      default: groupMask = widen(8'h00);
    endcase
  endfunction

  // register writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      portDataLatch_r <= widen(PORT_RESET);
    end else if (wrHit(regWr, regAddr, PORT_DATA_OFS)) begin
      portDataLatch_r <= widen(regWdata); // [R21]
    end
  end

  // direction and option kept apart so one write never disturbs the other
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dir_r <= widen(PORT_RESET);
    end else if (wrHit(regWr, regAddr, PORT_DIR_OFS)) begin
      dir_r <= widen(regWdata); // [R3]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      opt_r <= widen(PORT_RESET);
    end else if (wrHit(regWr, regAddr, PORT_OPT_OFS)) begin
      opt_r <= widen(regWdata); // [R3]
    end
  end

  // one control register serves all groups and the clock logic
  assign misc_nxt = wrHit(regWr, regAddr, MISC_OFS) ? regWdata : misc_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      misc_r <= MISC_RESET;
    end else begin
      misc_r <= misc_nxt;
    end
  end

  // named views of the control fields
  assign clkOutSel = misc_r[MCO_POS];
  assign slowSel = misc_r[SMS_POS];
  assign slowDiv = misc_r[PSM_LO +: 2];

  // a write that alters a pair clears both vectors of that pair
  always_comb begin
    polChange[0] = pairChanged(misc_nxt[PEI01_LO +: 2], misc_r[PEI01_LO +: 2]); // [R16]
    polChange[1] = polChange[0];
    polChange[2] = pairChanged(misc_nxt[PEI23_LO +: 2], misc_r[PEI23_LO +: 2]); // [R16]
    polChange[3] = polChange[2];
  end

  // input pins show the pad, output pins the latch
  assign pinView = (dir_r & portDataLatch_r) | (~dir_r & pinIn); // [R1] [R2] [R9]

  // register reads, data one cycle after the strobe
  always_comb begin
    case (regAddr)
      PORT_DATA_OFS: readMux = pad8(pinView);
      PORT_DIR_OFS: readMux = pad8(dir_r);
      PORT_OPT_OFS: readMux = pad8(opt_r);
      MISC_OFS: readMux = misc_r;
      // unmapped offsets read as zero
      default: readMux = 8'h00;
    endcase
  end

  // zero outside the answer cycle, so several slaves can be or-ed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_r <= 8'h00;
    end else if (regRd) begin
      regRdata_r <= readMux;
    end else begin
      regRdata_r <= 8'h00;
    end
  end

  assign regRdata = regRdata_r;

  // core clock prescaler from oscillator enable pulses
  always_comb begin
    if (!slowSel) begin
      divLimit = DIV_NORMAL; // [R19]
    end else begin
      case (slowDiv)
        2'h0: divLimit = DIV_SLOW0; // [R18]
        2'h1: divLimit = DIV_SLOW1; // [R18]
        2'h2: divLimit = DIV_SLOW2; // [R18]
        2'h3: divLimit = DIV_SLOW3; // [R18]
        default: divLimit = DIV_NORMAL;
      endcase
    end
  end

  // a divider change applies to the running period: it wraps at the new limit, or at once if the count is past it
  assign divWrap = osc_clk_en && (divCnt_r + 6'h01 >= divLimit); // [R18] [R19]
  assign divHalf = osc_clk_en && (divCnt_r + 6'h01 == (divLimit >> 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 6'h00;
    end else if (divWrap) begin
      divCnt_r <= 6'h00;
    end else if (osc_clk_en) begin
      divCnt_r <= divCnt_r + 6'h01;
    end
  end

  // one pulse per core clock period, for the enables of the core
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      coreClkEn_r <= 1'b0;
    end else begin
      coreClkEn_r <= divWrap;
    end
  end

  // square level: high from the wrap up to the half count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      coreClk_r <= 1'b0;
    end else if (divWrap) begin
      coreClk_r <= 1'b1;
    end else if (divHalf) begin
      coreClk_r <= 1'b0;
    end
  end

  assign coreClockEn = coreClkEn_r;
  assign coreClockLevel = coreClk_r;
  assign slowModeSelect = slowSel;
  assign slowClockDivider = slowDiv;

  // pad drive: next values per pin, clock out first, then peripheral
  always_comb begin
    pinOut_nxt = widen(8'h00);
    pinOe_nxt = widen(8'h00);
    pullUp_nxt = widen(8'h00);
    for (int i = 0; i < WIDTH; i++) begin
      if (i == CLKOUT_PIN && clkOutSel) begin
        pinOut_nxt[i] = coreClk_r; // [R17]
        pinOe_nxt[i] = 1'b1; // [R17]
      end else if (altEn[i] && !dir_r[i]) begin
        // peripheral in control; open drain only drives low
        pinOut_nxt[i] = altOut[i]; // [R8]
        pinOe_nxt[i] = altPushPull[i] | ~altOut[i]; // [R8]
      end else if (dir_r[i]) begin
        pinOut_nxt[i] = portDataLatch_r[i]; // [R2]
        pinOe_nxt[i] = opt_r[i] | ~portDataLatch_r[i]; // [R20]
      end else begin
        // plain input: pull-up only with the option set
        pullUp_nxt[i] = opt_r[i]; // [R1] [R20]
      end
    end
  end

  // registered so a mode change cannot glitch the pad
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinOut_r <= widen(8'h00);
    end else begin
      pinOut_r <= pinOut_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinOe_r <= widen(8'h00);
    end else begin
      pinOe_r <= pinOe_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pullUp_r <= widen(8'h00);
    end else begin
      pullUp_r <= pullUp_nxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign pullUpEn = pullUp_r;
  assign altIn = pinIn; // [R9]

  // only input pins with option set feed interrupts
  assign irqCapable = ~dir_r & opt_r; // [R7] [R20]

  // one detector per vector; requests reach the core as levels
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_grp
      gpext_irq_det #(.WIDTH(WIDTH)) u_det (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn(pinIn),
        .member(groupMask(gi) & irqCapable), // [R5] [R7]
        .pol(groupPol(gi, misc_r)), // [R14] [R15]
        .polChange(polChange[gi]),
        .ack(irqAck[gi]),
        .request(extIrq[gi])
      );
    end
  endgenerate
endmodule

// *** sim/gpext_chk.sv ***
// checker: port-level assertions for the gpio port block
module gpext_chk
  import gpext_pkg::*;
#(
  parameter logic [7:0] GROUP0_PINS = 8'h0f,
  parameter logic [7:0] GROUP3_PINS = 8'hf0,
  parameter int CLKOUT_PIN = 0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] altEn,
  input wire logic [7:0] altIn,
  input wire logic [NUM_GROUPS-1:0] irqAck,
  input wire logic [NUM_GROUPS-1:0] extIrq,
  input wire logic coreClockEn
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] dirM, latM, optM, miscM, rdX, puX, odX;
  logic [5:0] gap, calm, divX;
  logic mw, core_clock_out_enable, g0, g3;
  // mirrors of the registers, so checks need no view inside
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {dirM, latM, optM, miscM} <= 32'h0;
    end else if (regWr) begin
      if (regAddr == PORT_DATA_OFS) latM <= regWdata;
      if (regAddr == PORT_DIR_OFS) dirM <= regWdata;
      if (regAddr == PORT_OPT_OFS) optM <= regWdata;
      if (regAddr == MISC_OFS) miscM <= regWdata;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 6'h0;
      calm <= 6'h0;
    end else begin
      gap <= coreClockEn ? 6'h0 : gap + 6'h1;
      calm <= mw ? 6'h0 : calm + {5'h0, calm != 6'h3f};
    end
  end
  assign mw = regWr && regAddr == MISC_OFS;
  assign core_clock_out_enable = miscM[MCO_POS];
  assign rdX = (dirM & latM) | (~dirM & pinIn);
  assign puX = ~dirM & optM;
  assign odX = dirM & (optM | ~latM);
  assign g0 = &(pinIn | ~(GROUP0_PINS & puX));
  assign g3 = &(pinIn | ~(GROUP3_PINS & puX));
  always_comb begin
    case ({miscM[SMS_POS], miscM[PSM_LO+:2]})
      3'h4: divX = DIV_SLOW0;
      3'h5: divX = DIV_SLOW1;
      3'h6: divX = DIV_SLOW2;
      3'h7: divX = DIV_SLOW3;
      default: divX = DIV_NORMAL;
    endcase
  end
  sequence s_event(g, logic [1:0] m);
    ($fell(g) && m != POL_RISE) || ($rose(g) && m[0]);
  endsequence
  // an ack or a polarity write inside the window may clear the request
  sequence s_quiet(a);
    (!a && !mw) [*4];
  endsequence
  a_read_data:
    assert property (regRd && regAddr == PORT_DATA_OFS |=> regRdata == $past(rdX))
    else $error("data read wrong");
  a_idle_zero:
    assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero");
  a_pull_up:
    assert property ($past(altEn) == 8'h00 |->
      pullUpEn == ($past(puX) & ~($past(core_clock_out_enable) ? (8'h01 << CLKOUT_PIN) : 8'h00)))
    else $error("pull-up wrong");
  a_out_drive:
    assert property ($past(altEn) == 8'h00 && !$past(core_clock_out_enable) |-> (pinOe & $past(dirM)) == $past(odX))
    else $error("output enable wrong");
  a_alt_in:
    assert property (altIn == pinIn)
    else $error("alt input wrong");
  a_clk_out:
    assert property ($past(core_clock_out_enable) && core_clock_out_enable |-> pinOe[CLKOUT_PIN])
    else $error("clock pin not driven");
  a_div_period:
    assert property (coreClockEn && calm > 6'h28 |-> gap == divX - 6'h1)
    else $error("core clock period wrong");
  a_edge_g0:
    assert property (s_event(g0, miscM[PEI01_LO+:2]) ##0 s_quiet(irqAck[0]) |-> extIrq[0])
    else $error("group0 request missing");
  a_edge_g3:
    assert property (s_event(g3, miscM[PEI23_LO+:2]) ##0 s_quiet(irqAck[3]) |-> extIrq[3])
    else $error("group3 request missing");
endmodule

// *** sim/gpext_pins.sv ***
// external pin partner: pad drive, pull-up, bench drive, floating drift
module gpext_pins
  import gpext_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] extDrv,
  input wire logic [7:0] extEn,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // a pin nobody drives does not keep its last level
  logic [7:0] drift = 8'h5a;
  always @(posedge ref_clk) drift <= ~drift;
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extDrv)
    | (~pinOe & ~extEn & (pullUpEn | drift));
endmodule

// *** sim/tb_top.sv ***
// top testbench: register model, pin partner and scenarios
`define CHK(g, e, m) begin \
  compares++; \
  if ((g) !== (e)) begin \
    errCount++; \
    $display("wrong value t=%0t %s", $time, m); \
  end \
end
module tb_top;
  import gpext_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata, pinIn, pinOut, pinOe, pullUpEn;
  logic [7:0] altEn, altOut, altPushPull, altIn, extDrv, extEn;
  logic regWr, regRd, coreClockEn, coreClockLevel, slowModeSelect;
  logic [3:0] irqAck, extIrq;
  logic [1:0] slowClockDivider;
  bit [7:0] mDir, mLat, mOpt, mMisc;
  int errCount, compares, cyc, n, h;
  logic [7:0] regs[5] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h07};
  int cnt[5] = '{16, 4, 8, 2, 32};
  gpext_port dut (.*, .osc_clk_en(1'b1));
  gpext_pins pins (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic wrapUp();
    $display("errors %0d compares %0d", errCount, compares);
    if (errCount == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errCount++;
      wrapUp();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    if (a == PORT_DATA_OFS) mLat = d;
    if (a == PORT_DIR_OFS) mDir = d;
    if (a == PORT_OPT_OFS) mOpt = d;
    if (a == MISC_OFS) mMisc = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    e = a == PORT_DATA_OFS ? (mDir & mLat) | (~mDir & pinIn) : a == PORT_DIR_OFS ? mDir
      : a == PORT_OPT_OFS ? mOpt : a == MISC_OFS ? mMisc : 8'h00;
    #1 `CHK(regRdata, e, "read")
  endtask
  task automatic pads();
    bit [7:0] oe, om;
    repeat (2) @(posedge ref_clk);
    #1;
    oe = (mDir & (mOpt | ~mLat)) | (~mDir & altEn & (altPushPull | ~altOut));
    om = mDir | altEn;
    `CHK(pinOe, oe, "enable")
    `CHK(pinOut & om, (mLat & mDir) | (altOut & altEn & ~mDir), "out")
    `CHK(pullUpEn, ~mDir & mOpt, "pull")
  endtask
  task automatic ack();
    repeat (3) @(posedge ref_clk);
    irqAck <= 4'hf;
    @(posedge ref_clk);
    irqAck <= 4'h0;
  endtask
  task automatic waitChk(input logic [3:0] e);
    repeat (5) @(posedge ref_clk);
    #1 `CHK(extIrq, e, "irq")
  endtask
  initial begin
    {regAddr, regWdata, altEn, altOut, altPushPull, extDrv, extEn} = 56'h0;
    {regWr, regRd, irqAck} = 6'h0;
    void'($urandom(90));
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (regs[i]) rd(regs[i]);
    repeat (8) begin
      wr(PORT_DATA_OFS, 8'($urandom));
      wr(PORT_OPT_OFS, 8'($urandom));
      wr(PORT_DIR_OFS, 8'($urandom));
      extEn <= ~mDir & 8'($urandom);
      extDrv <= 8'($urandom);
      rd(PORT_DATA_OFS);
      pads();
    end
    wr(PORT_DIR_OFS, 8'h00);
    wr(PORT_OPT_OFS, 8'h00);
    extEn <= 8'h00;
    repeat (4) begin
      altEn <= 8'($urandom);
      altOut <= 8'($urandom);
      altPushPull <= 8'($urandom);
      pads();
      `CHK(altIn, pinIn, "alt")
      rd(PORT_DATA_OFS);
    end
    altEn <= 8'h00;
    wr(PORT_OPT_OFS, 8'hff);
    extEn <= 8'hff;
    for (int m = 0; m < 4; m++) begin
      extDrv <= 8'hff;
      wr(MISC_OFS, {2'(m), 1'h0, 2'(m), 3'h0});
      ack();
      extDrv <= 8'hdd;
      waitChk(m != 1 ? 4'h9 : 4'h0);
      ack();
      waitChk(m == 0 ? 4'h9 : 4'h0);
      extDrv <= 8'hff;
      waitChk(m[0] ? 4'h9 : 4'h0);
      wr(MISC_OFS, {2'(m + 1), 1'h0, 2'(m + 1), 3'h0});
      waitChk(4'h0);
    end
    extEn <= 8'h00;
    wr(PORT_OPT_OFS, 8'h00);
    for (int s = 0; s < 5; s++) begin
      wr(MISC_OFS, s == 4 ? 8'h20 : 8'(s * 2 + 1));
      repeat (40) @(posedge ref_clk);
      n = 0;
      h = 0;
      repeat (64) begin
        @(posedge ref_clk);
        n += coreClockEn;
        h += coreClockLevel;
      end
      `CHK(n, cnt[s], "divider")
      `CHK(h, 32, "level")
      `CHK({slowClockDivider, slowModeSelect}, mMisc[2:0], "mode")
      `CHK(pinOe[0], mMisc[5], "clock out")
    end
    wrapUp();
  end
endmodule
bind gpext_port gpext_chk #(.GROUP0_PINS(GROUP0_PINS), .GROUP3_PINS(GROUP3_PINS),
  .CLKOUT_PIN(CLKOUT_PIN)) chk (.*);
